/* File: adcsr_regs.svh */
`ifndef ADCSR_REGS_SVH
`define ADCSR_REGS_SVH

////////////////////////////////////////////////////////////////////////
// timing
`define ADCSR_CLK_MHZ        10
`define ADCSR_POR_TIME_US    1000
`define ADCSR_POR_CYCLES     (`ADCSR_POR_TIME_US * `ADCSR_CLK_MHZ)
`define ADCSR_CAL_CYCLES     8'h10
`define ADCSR_SCK_DIV        8

////////////////////////////////////////////////////////////////////////
// serial word layout
`define ADCSR_WORD_BITS      5'h13
`define ADCSR_LAST_FALL      5'h12
`define ADCSR_EOC_POS        18
`define ADCSR_DMY_POS        17
`define ADCSR_POL_POS        16
`define ADCSR_MSB_POS        15
`define ADCSR_OVER_CODE      16'h8000
`define ADCSR_UNDER_CODE     16'h7fff
`define ADCSR_FILL_BIT       1'b1

////////////////////////////////////////////////////////////////////////
// host register map and fields
`define ADCSR_HOST_CTRL      4'h0
`define ADCSR_HOST_STAT      4'h1
`define ADCSR_HOST_DATA      4'h2
`define ADCSR_HOST_HALF      4'h3
`define ADCSR_CTRL_START     0
`define ADCSR_CTRL_EXT       1
`define ADCSR_CTRL_ABORT     2
`define ADCSR_STAT_BUSY      0
`define ADCSR_STAT_DONE      1
`define ADCSR_STAT_SDO       2
`define ADCSR_HALF_RST       8'h08
`define ADCSR_EXT_RST        1'b0

`endif

/* File: adcsr_pkg.sv */
package adcsr_pkg;

    typedef enum logic [1:0] {
        ADCSR_POR   = 2'b00,
        ADCSR_CONV  = 2'b01,
        ADCSR_SLEEP = 2'b10,
        ADCSR_OUT   = 2'b11
    } adcsr_dev_state_t;

    typedef enum logic [1:0] {
        ADCSR_CAL_OFS  = 2'b00,
        ADCSR_CAL_FS   = 2'b01,
        ADCSR_CAL_MEAS = 2'b10
    } adcsr_cal_t;

    typedef enum logic [2:0] {
        ADCSR_H_IDLE   = 3'b000,
        ADCSR_H_SETUP  = 3'b001,
        ADCSR_H_SELECT = 3'b010,
        ADCSR_H_WAIT   = 3'b011,
        ADCSR_H_CLKLO  = 3'b100,
        ADCSR_H_CLKHI  = 3'b101,
        ADCSR_H_RXINT  = 3'b110,
        ADCSR_H_FINISH = 3'b111
    } adcsr_host_state_t;

endpackage : adcsr_pkg

/* File: adcsr_if.sv */
`timescale 1ns/1ps
interface adcsr_if;
    logic cs_n;
    logic sck_dev_o;
    logic sck_dev_oe;
    logic sck_host_o;
    logic sck_host_oe;
    logic sdo_o;
    logic sdo_oe;
    logic sck;
    logic serial_data_out;

    // undriven clock pin floats high through the weak pullup
    assign sck = sck_dev_oe ? sck_dev_o : (sck_host_oe ? sck_host_o : 1'b1);
    assign serial_data_out = sdo_oe ? sdo_o : 1'b1;

    modport dev (
        input  cs_n,
        input  sck,
        output sck_dev_o,
        output sck_dev_oe,
        output sdo_o,
        output sdo_oe
    );

    modport host (
        output cs_n,
        output sck_host_o,
        output sck_host_oe,
        input  sck,
        input  serial_data_out,
        input  sdo_oe
    );
endinterface : adcsr_if

/* File: adcsr_dev.sv */
`timescale 1ns/1ps
`include "adcsr_regs.svh"

module adcsr_dev #(
    parameter int POR_CYCLES = `ADCSR_POR_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    adcsr_if.dev                          link,
    input  wire logic                     conv_done_i,
    input  wire logic [15:0]              conv_value_i,
    input  wire logic                     conv_over_i,
    input  wire logic                     conv_under_i,
    output logic                          conv_start_o,
    output adcsr_pkg::adcsr_cal_t         cal_phase_o,
    output adcsr_pkg::adcsr_dev_state_t   state_o,
    output logic                          ext_mode_o
);
    import adcsr_pkg::*;

    localparam logic [19:0] POR_LAST = 20'(POR_CYCLES - 1);
    localparam int          DIV_MSB  = $clog2(`ADCSR_SCK_DIV) - 1;

    ////////////////////////////////////////////////////////////////////
    // state
    adcsr_dev_state_t state_r;
    adcsr_dev_state_t state_nxt;
    adcsr_cal_t       cal_r;
    adcsr_cal_t       cal_nxt;
    logic [19:0]      por_cnt_r;
    logic [19:0]      por_cnt_nxt;
    logic [7:0]       cal_cnt_r;
    logic [7:0]       cal_cnt_nxt;
    logic [18:0]      shift_r;
    logic [18:0]      shift_nxt;
    logic [4:0]       fall_cnt_r;
    logic [4:0]       fall_cnt_nxt;
    logic [DIV_MSB:0] div_r;
    logic [DIV_MSB:0] div_nxt;
    logic             started_r;
    logic             started_nxt;
    logic             ext_r;
    logic             ext_nxt;
    logic             sck_prev_r;
    logic             cs_prev_r;
    logic             sdo_r;
    logic             sdo_nxt;
    logic             start_r;
    logic             start_nxt;
    logic             sck_rise;
    logic             sck_fall;
    logic             cs_fall;
    logic             pol;
    logic [15:0]      code;

    ////////////////////////////////////////////////////////////////////
    // result formatting
    always_comb begin
        if (conv_over_i) begin
            pol  = 1'b1;
            code = `ADCSR_OVER_CODE;
        end else if (conv_under_i) begin
            pol  = 1'b0;
            code = `ADCSR_UNDER_CODE;
        end else begin
            pol  = ~conv_value_i[15];
            code = conv_value_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        state_nxt    = state_r;
        cal_nxt      = cal_r;
        por_cnt_nxt  = por_cnt_r;
        cal_cnt_nxt  = cal_cnt_r;
        shift_nxt    = shift_r;
        fall_cnt_nxt = fall_cnt_r;
        div_nxt      = div_r;
        started_nxt  = started_r;
        ext_nxt      = ext_r;
        start_nxt    = 1'b0;
        sck_rise     = link.sck & ~sck_prev_r;
        sck_fall     = ~link.sck & sck_prev_r;
        cs_fall      = cs_prev_r & ~link.cs_n;

        if (cs_fall) begin
            ext_nxt = ~link.sck;
        end

        case (state_r)
            ADCSR_POR: begin
                por_cnt_nxt = por_cnt_r + 20'h00001;
                if (por_cnt_r == POR_LAST) begin
                    state_nxt = ADCSR_CONV;
                    start_nxt = 1'b1;
                    ext_nxt   = ~link.sck;
                end
            end
            ADCSR_CONV: begin
                // calibration runs in the background of the conversion:
                // it never gates the completion, so host timing is unchanged
                if (cal_r != ADCSR_CAL_MEAS) begin
                    cal_cnt_nxt = cal_cnt_r + 8'h01;
                    if (cal_cnt_r == `ADCSR_CAL_CYCLES - 8'h01) begin
                        cal_cnt_nxt = 8'h00;
                        cal_nxt     = (cal_r == ADCSR_CAL_OFS) ? ADCSR_CAL_FS
                                                               : ADCSR_CAL_MEAS;
                    end
                end
                if (conv_done_i) begin
                    shift_nxt = {1'b0, 1'b0, pol, code};
                    state_nxt = ADCSR_SLEEP;
                end
            end
            ADCSR_SLEEP: begin
                fall_cnt_nxt = 5'h00;
                started_nxt  = 1'b0;
                div_nxt      = '0;
                if (!link.cs_n) begin
                    state_nxt = ADCSR_OUT;
                end
            end
            default: begin
                if (link.cs_n) begin
                    if (started_r) begin
                        state_nxt = ADCSR_CONV;
                        start_nxt = 1'b1;
                    end else begin
                        state_nxt = ADCSR_SLEEP;
                    end
                end else begin
                    if (!ext_r) begin
                        div_nxt = div_r + 1'b1;
                    end
                    if (sck_rise) begin
                        started_nxt = 1'b1;
                    end
                    if (sck_fall && started_r) begin
                        shift_nxt    = {shift_r[17:0], `ADCSR_FILL_BIT};
                        fall_cnt_nxt = fall_cnt_r + 5'h01;
                        if (fall_cnt_r == `ADCSR_LAST_FALL) begin
                            state_nxt = ADCSR_CONV;
                            start_nxt = 1'b1;
                        end
                    end
                end
            end
        endcase

        if (start_nxt) begin
            cal_nxt     = ADCSR_CAL_OFS;
            cal_cnt_nxt = 8'h00;
        end

        // end flag is high whenever a conversion is running, so the
        // first bit after the last data bit is the next cycle's flag
        if (state_nxt == ADCSR_CONV || state_nxt == ADCSR_POR) begin
            sdo_nxt = 1'b1;
        end else begin
            sdo_nxt = shift_nxt[`ADCSR_EOC_POS];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r    <= ADCSR_POR;
            cal_r      <= ADCSR_CAL_OFS;
            por_cnt_r  <= 20'h00000;
            cal_cnt_r  <= 8'h00;
            shift_r    <= 19'h00000;
            fall_cnt_r <= 5'h00;
            div_r      <= '0;
            started_r  <= 1'b0;
            ext_r      <= 1'b0;
            sck_prev_r <= 1'b1;
            cs_prev_r  <= 1'b1;
            sdo_r      <= 1'b1;
            start_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cal_r      <= cal_nxt;
            por_cnt_r  <= por_cnt_nxt;
            cal_cnt_r  <= cal_cnt_nxt;
            shift_r    <= shift_nxt;
            fall_cnt_r <= fall_cnt_nxt;
            div_r      <= div_nxt;
            started_r  <= started_nxt;
            ext_r      <= ext_nxt;
            sck_prev_r <= link.sck;
            cs_prev_r  <= link.cs_n;
            sdo_r      <= sdo_nxt;
            start_r    <= start_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pins
    assign link.sdo_o     = sdo_r;
    assign link.sdo_oe    = ~link.cs_n;
    assign link.sck_dev_o = div_r[DIV_MSB];
    // clock is driven only while selected in the output state; the pin
    // is released at once on select rise so the host can take it back
    assign link.sck_dev_oe = (state_r == ADCSR_OUT) & ~ext_r & ~link.cs_n;

    assign conv_start_o = start_r;
    assign cal_phase_o  = cal_r;
    assign state_o      = state_r;
    assign ext_mode_o   = ext_r;

endmodule : adcsr_dev

/* File: adcsr_host.sv */
`timescale 1ns/1ps
`include "adcsr_regs.svh"

module adcsr_host (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    adcsr_if.host            link,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o
);
    import adcsr_pkg::*;

    adcsr_host_state_t state_r;
    adcsr_host_state_t state_nxt;
    logic [7:0]        half_r;
    logic [7:0]        half_nxt;
    logic [7:0]        cnt_r;
    logic [7:0]        cnt_nxt;
    logic [4:0]        bits_r;
    logic [4:0]        bits_nxt;
    logic [18:0]       data_r;
    logic [18:0]       data_nxt;
    logic              ext_r;
    logic              ext_nxt;
    logic              done_r;
    logic              done_nxt;
    logic              cs_n_r;
    logic              cs_n_nxt;
    logic              sck_r;
    logic              sck_nxt;
    logic              sck_oe_r;
    logic              sck_oe_nxt;
    logic              sck_prev_r;
    logic [31:0]       rdata_r;
    logic [31:0]       rdata_nxt;
    logic              rise;
    logic              wr_ctrl;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt  = state_r;
        half_nxt   = half_r;
        cnt_nxt    = cnt_r;
        bits_nxt   = bits_r;
        data_nxt   = data_r;
        ext_nxt    = ext_r;
        done_nxt   = done_r;
        cs_n_nxt   = cs_n_r;
        sck_nxt    = sck_r;
        sck_oe_nxt = sck_oe_r;
        rdata_nxt  = 32'h00000000;
        rise       = link.sck & ~sck_prev_r;
        wr_ctrl    = wr_i && (addr_i == `ADCSR_HOST_CTRL);

        if (wr_i && addr_i == `ADCSR_HOST_HALF) begin
            half_nxt = wdata_i[7:0];
        end
        if (wr_i && addr_i == `ADCSR_HOST_STAT && wdata_i[`ADCSR_STAT_DONE]) begin
            done_nxt = 1'b0;
        end

        // latch each bit on a rising clock edge, status bits first
        if ((state_r == ADCSR_H_CLKLO || state_r == ADCSR_H_CLKHI ||
             state_r == ADCSR_H_RXINT) && rise && bits_r != `ADCSR_WORD_BITS) begin
            data_nxt = {data_r[17:0], link.serial_data_out};
            bits_nxt = bits_r + 5'h01;
        end

        case (state_r)
            ADCSR_H_IDLE: begin
                sck_oe_nxt = 1'b0;
                if (wr_ctrl) begin
                    ext_nxt = wdata_i[`ADCSR_CTRL_EXT];
                    if (wdata_i[`ADCSR_CTRL_START]) begin
                        state_nxt = ADCSR_H_SETUP;
                    end
                end
            end
            ADCSR_H_SETUP: begin
                // clock level must be settled before select falls
                sck_nxt    = 1'b0;
                sck_oe_nxt = ext_r;
                state_nxt  = ADCSR_H_SELECT;
            end
            ADCSR_H_SELECT: begin
                cs_n_nxt  = 1'b0;
                bits_nxt  = 5'h00;
                cnt_nxt   = 8'h00;
                state_nxt = ext_r ? ADCSR_H_WAIT : ADCSR_H_RXINT;
            end
            ADCSR_H_WAIT: begin
                if (link.sdo_oe && !link.serial_data_out) begin
                    state_nxt = ADCSR_H_CLKLO;
                end
            end
            ADCSR_H_CLKLO: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r >= half_r - 8'h01) begin
                    cnt_nxt   = 8'h00;
                    sck_nxt   = 1'b1;
                    state_nxt = ADCSR_H_CLKHI;
                end
            end
            ADCSR_H_CLKHI: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r >= half_r - 8'h01) begin
                    cnt_nxt = 8'h00;
                    if (bits_r == `ADCSR_WORD_BITS) begin
                        // the 19th fall ends the frame; select stays low two
                        // more cycles so the next end flag shows on the pin
                        sck_nxt   = 1'b0;
                        state_nxt = ADCSR_H_RXINT;
                    end else begin
                        sck_nxt   = 1'b0;
                        state_nxt = ADCSR_H_CLKLO;
                    end
                end
            end
            ADCSR_H_RXINT: begin
                if (bits_r == `ADCSR_WORD_BITS) begin
                    state_nxt = ADCSR_H_FINISH;
                end
            end
            default: begin
                // internal mode: select rise after the last rise starts a conversion
                cs_n_nxt   = 1'b1;
                sck_oe_nxt = 1'b0;
                done_nxt   = 1'b1;
                state_nxt  = ADCSR_H_IDLE;
            end
        endcase

        if (wr_ctrl && wdata_i[`ADCSR_CTRL_ABORT] && state_r != ADCSR_H_IDLE) begin
            cs_n_nxt   = 1'b1;
            sck_oe_nxt = 1'b0;
            state_nxt  = ADCSR_H_IDLE;
        end

        if (rd_i) begin
            if (addr_i == `ADCSR_HOST_CTRL) begin
                rdata_nxt[`ADCSR_CTRL_EXT] = ext_r;
            end else if (addr_i == `ADCSR_HOST_STAT) begin
                rdata_nxt[`ADCSR_STAT_BUSY] = (state_r != ADCSR_H_IDLE);
                rdata_nxt[`ADCSR_STAT_DONE] = done_r;
                rdata_nxt[`ADCSR_STAT_SDO]  = link.serial_data_out;
            end else if (addr_i == `ADCSR_HOST_DATA) begin
                rdata_nxt[18:0] = data_r;
            end else if (addr_i == `ADCSR_HOST_HALF) begin
                rdata_nxt[7:0] = half_r;
            end else begin
                rdata_nxt = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r    <= ADCSR_H_IDLE;
            half_r     <= `ADCSR_HALF_RST;
            cnt_r      <= 8'h00;
            bits_r     <= 5'h00;
            data_r     <= 19'h00000;
            ext_r      <= `ADCSR_EXT_RST;
            done_r     <= 1'b0;
            cs_n_r     <= 1'b1;
            sck_r      <= 1'b0;
            sck_oe_r   <= 1'b0;
            sck_prev_r <= 1'b1;
            rdata_r    <= 32'h00000000;
        end else begin
            state_r    <= state_nxt;
            half_r     <= half_nxt;
            cnt_r      <= cnt_nxt;
            bits_r     <= bits_nxt;
            data_r     <= data_nxt;
            ext_r      <= ext_nxt;
            done_r     <= done_nxt;
            cs_n_r     <= cs_n_nxt;
            sck_r      <= sck_nxt;
            sck_oe_r   <= sck_oe_nxt;
            sck_prev_r <= link.sck;
            rdata_r    <= rdata_nxt;
        end
    end

    assign link.cs_n        = cs_n_r;
    assign link.sck_host_o  = sck_r;
    assign link.sck_host_oe = sck_oe_r;
    assign rdata_o          = rdata_r;

endmodule : adcsr_host

/* File: adcsr_checker.sv */
`timescale 1ns/1ps
module adcsr_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic serial_data_out,
    input wire logic sdo_oe,
    input wire logic sck_dev_oe,
    input wire logic sck_host_oe
);
    logic [4:0] rise_cnt_r;
    logic [4:0] rise_cnt_nxt;
    logic       sck_q_r;

    ////////////////////////////////////////////////////////////////////////
    // clock rises within one selection, whichever end makes them
    always_comb begin
        rise_cnt_nxt = rise_cnt_r;
        if (cs_n) begin
            rise_cnt_nxt = 5'h00;
        end else if (sck && !sck_q_r && rise_cnt_r != 5'h1f) begin
            rise_cnt_nxt = rise_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rise_cnt_r <= 5'h00;
            sck_q_r <= 1'b1;
        end else begin
            rise_cnt_r <= rise_cnt_nxt;
            sck_q_r <= sck;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // internal clock is clk/8: four cycles per level
    sequence hi4_s;
        sck [*4];
    endsequence
    sequence lo4_s;
        !sck [*4];
    endsequence

    hiz_sel_a: assert property (cs_n |-> !sdo_oe)
        else $error("data pin driven while deselected");
    sel_drv_a: assert property (!cs_n |-> sdo_oe)
        else $error("data pin released while selected");
    one_drv_a: assert property (!(sck_dev_oe && sck_host_oe))
        else $error("both ends drive the clock pin");
    clk_sel_a: assert property ($rose(sck_dev_oe) |-> !cs_n)
        else $error("device clock started while deselected");
    clk_high_a: assert property ($rose(sck) && sck_dev_oe |-> hi4_s)
        else $error("internal clock high phase not four cycles");
    clk_low_a: assert property ($fell(sck) && sck_dev_oe |-> lo4_s)
        else $error("internal clock low phase not four cycles");
    ext_mode_a: assert property ($fell(cs_n) && !sck |-> !sck_dev_oe [*4])
        else $error("device drove clock in external mode");
    sdo_hold_a: assert property ($rose(sck) && !cs_n |=> cs_n || $stable(serial_data_out))
        else $error("data changed right after a rising clock");
    rise_cnt_a: assert property (rise_cnt_r <= 5'h13)
        else $error("more than nineteen clock rises in one selection");
    eoc_next_a: assert property ($fell(sck) && !cs_n && rise_cnt_r == 5'h13 |=> cs_n || serial_data_out)
        else $error("next end flag not shown after the last fall");
endmodule : adcsr_checker

/* File: adc_serial_result_readout_tb_top.sv */
`timescale 1ns/1ps
`include "adcsr_regs.svh"
module adc_serial_result_readout_tb_top;
    import adcsr_pkg::*;
    logic             clk_i;
    logic             rst_b_i;
    logic             done;
    logic [15:0]      val;
    logic             over;
    logic             under;
    logic [3:0]       addr;
    logic [31:0]      wdata;
    logic             wr;
    logic             rd;
    logic [31:0]      rdata;
    logic             ext;
    logic [31:0]      rv;
    adcsr_dev_state_t st;
    adcsr_cal_t       cal;
    logic             cstart;
    int               n_starts = 0;
    int               n_errors;
    int               total_checks;

    adcsr_if adcsr_if_i ();
    adcsr_dev #(.POR_CYCLES(20)) adcsr_dev_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .link(adcsr_if_i.dev),
        .conv_done_i(done), .conv_value_i(val), .conv_over_i(over),
        .conv_under_i(under), .conv_start_o(cstart), .cal_phase_o(cal), .state_o(st),
        .ext_mode_o(ext));
    adcsr_host adcsr_host_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .link(adcsr_if_i.host), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    adcsr_checker adcsr_checker_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_n(adcsr_if_i.cs_n),
        .sck(adcsr_if_i.sck), .serial_data_out(adcsr_if_i.serial_data_out), .sdo_oe(adcsr_if_i.sdo_oe),
        .sck_dev_oe(adcsr_if_i.sck_dev_oe), .sck_host_oe(adcsr_if_i.sck_host_oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask : rreg

    // bounded wait; a hang shows as a state mismatch, not a stall
    task automatic wait_st(input adcsr_dev_state_t s);
        int k;
        k = 0;
        while (st !== s && k < 2000) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk("state", {30'h0, s}, {30'h0, st});
    endtask : wait_st

    task automatic pulse(input logic [15:0] v, input logic ov, input logic un, input int dly);
        wait_st(ADCSR_CONV);
        repeat (dly + 1) @(posedge clk_i);
        done <= 1'b1;
        val <= v;
        over <= ov;
        under <= un;
        @(posedge clk_i);
        done <= 1'b0;
        wait_st(ADCSR_SLEEP);
    endtask : pulse

    task automatic conv(input logic [15:0] v, input logic ov, input logic un,
                        input logic e, input int dly);
        logic [31:0] exp;
        int k;
        exp = ov ? 32'h0001_8000 : (un ? 32'h0000_7fff : {15'h0, ~v[15], v});
        pulse(v, ov, un, dly);
        wreg(`ADCSR_HOST_CTRL, {30'h0, e, 1'b1});
        k = 0;
        rv = 32'h0;
        while (rv[1] !== 1'b1 && k < 500) begin
            rreg(`ADCSR_HOST_STAT);
            k++;
        end
        chk("done", 32'h0000_0001, {31'h0, rv[1]});
        chk("mode", {31'h0, e}, {31'h0, ext});
        rreg(`ADCSR_HOST_DATA);
        chk("word", exp, rv);
        wreg(`ADCSR_HOST_STAT, 32'h0000_0002);
    endtask : conv

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // one count per conversion start, seen the edge after the pulse
    always @(posedge clk_i) begin
        if (cstart === 1'b1) begin
            n_starts <= n_starts + 1;
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end

    initial begin
        rst_b_i = 1'b0;
        done = 1'b0;
        val = 16'h0000;
        over = 1'b0;
        under = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        chk("por", {30'h0, ADCSR_POR}, {30'h0, st});
        repeat (15) @(posedge clk_i);
        #1;
        chk("start", {30'h0, ADCSR_CONV}, {30'h0, st});
        chk("cal", {30'h0, ADCSR_CAL_OFS}, {30'h0, cal});
        rreg(`ADCSR_HOST_HALF);
        chk("half", 32'h0000_0008, rv);
        rreg(4'h5);
        chk("unmapped", 32'h0, rv);
        repeat (30) @(posedge clk_i);
        #1;
        chk("cal", {30'h0, ADCSR_CAL_MEAS}, {30'h0, cal});
        // done lands in offset, full-scale and measure phases
        conv(16'h0000, 1'b0, 1'b0, 1'b1, 0);
        conv(16'hffff, 1'b0, 1'b0, 1'b0, 20);
        conv(16'h7fff, 1'b0, 1'b0, 1'b1, 40);
        conv(16'h8000, 1'b0, 1'b0, 1'b0, 5);
        conv(16'h1234, 1'b1, 1'b0, 1'b1, 30);
        conv(16'h1234, 1'b0, 1'b1, 1'b0, 10);
        conv(16'h0000, 1'b1, 1'b1, 1'b1, 0);
        pulse(16'h4000, 1'b0, 1'b0, 3);
        wreg(`ADCSR_HOST_CTRL, 32'h0000_0003);
        repeat (80) @(posedge clk_i);
        wreg(`ADCSR_HOST_CTRL, 32'h0000_0006);
        wait_st(ADCSR_CONV);
        rreg(`ADCSR_HOST_STAT);
        chk("status", 32'h0000_0004, rv);
        chk("starts", 32'h0000_0009, n_starts);
        print_verdict();
    end
endmodule : adc_serial_result_readout_tb_top
